//--- tb/bphs_boot_seq_monitor.sv
// Port checker for the boot sequencer.
`timescale 1ns/1ps
module bphs_boot_seq_monitor (
  // Clock, reset and straps
  input wire        CORE_CLK,
  input wire        RST_N,
  input wire [3:0]  BOOT_MODE,
  input wire        FAST_BOOT,
  input wire        PCI_ENABLE_STRAP,
  // Sequencer outputs
  input wire [1:0]  PLL_POSTDIV,
  input wire        PLL_BYPASS,
  input wire        HOST_INTERRUPT,
  input wire        PCI_CONFIG_READY,
  input wire        EE_READ_REQ,
  input wire        EMU_IDLE,
  input wire        JUMP_VALID,
  input wire [31:0] JUMP_ADDR
);
  // Consecutive cycles the interrupt has been high, saturating.
  logic [3:0] host_interrupt_run;
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N)
      host_interrupt_run <= 4'h0;
    else if (!HOST_INTERRUPT)
      host_interrupt_run <= 4'h0;
    else if (host_interrupt_run != 4'hF)
      host_interrupt_run <= host_interrupt_run + 4'h1;
  end
  default clocking dc @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  AST_EMU: assert property (EMU_IDLE |-> PLL_BYPASS && !JUMP_VALID)
    else $error("emulation left bypass");
  AST_NO_PLL: assert property (BOOT_MODE == 4'h0 || !FAST_BOOT |-> PLL_BYPASS)
    else $error("pll programmed");
  AST_POSTDIV: assert property (!PLL_BYPASS |-> PLL_POSTDIV == 2'h1)
    else $error("post divider");
  AST_HOST_INTERRUPT_LEN: assert property ($fell(HOST_INTERRUPT) |-> host_interrupt_run == 4'hA)
    else $error("interrupt length");
  AST_HOST_INTERRUPT_MAX: assert property (HOST_INTERRUPT |-> host_interrupt_run < 4'hA)
    else $error("interrupt too long");
  AST_HOST_INTERRUPT_PLL: assert property ($rose(HOST_INTERRUPT) |->
    !PCI_ENABLE_STRAP && PLL_BYPASS != FAST_BOOT) else $error("interrupt early");
  AST_READY_PLL: assert property ($rose(PCI_CONFIG_READY) |->
    PCI_ENABLE_STRAP && PLL_BYPASS != FAST_BOOT) else $error("ready early");
  AST_EE_GATE: assert property (EE_READ_REQ |->
    BOOT_MODE == 4'h2 && PCI_ENABLE_STRAP && FAST_BOOT) else $error("eeprom read");
  AST_EE_READY: assert property (EE_READ_REQ |-> !PCI_CONFIG_READY)
    else $error("ready during walk");
  AST_JUMP_HOLD: assert property (JUMP_VALID |=> JUMP_VALID && $stable(JUMP_ADDR))
    else $error("jump changed");
  C_HOST_INTERRUPT: cover property ($rose(HOST_INTERRUPT));
  C_READY: cover property ($rose(PCI_CONFIG_READY));
  C_JUMP: cover property ($rose(JUMP_VALID));
endmodule // bphs_boot_seq_monitor
bind bphs_boot_seq bphs_boot_seq_monitor u_mon (
  .CORE_CLK         (CORE_CLK),
  .RST_N            (RST_N),
  .BOOT_MODE        (BOOT_MODE),
  .FAST_BOOT        (FAST_BOOT),
  .PCI_ENABLE_STRAP (PCI_ENABLE_STRAP),
  .PLL_POSTDIV      (PLL_POSTDIV),
  .PLL_BYPASS       (PLL_BYPASS),
  .HOST_INTERRUPT   (HOST_INTERRUPT),
  .PCI_CONFIG_READY (PCI_CONFIG_READY),
  .EE_READ_REQ      (EE_READ_REQ),
  .EMU_IDLE         (EMU_IDLE),
  .JUMP_VALID       (JUMP_VALID),
  .JUMP_ADDR        (JUMP_ADDR)
);

//--- tb/bphs_boot_seq_tb.sv
// Self-checking bench for the boot sequencer.
`timescale 1ns/1ps
module bphs_boot_seq_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  md = 4'h0;
  logic        fb = 1'b0;
  logic        pe = 1'b0;
  logic [2:0]  bc = 3'h0;
  logic [2:0]  ms = 3'h0;
  wire  [3:0]  ra;
  wire  [31:0] wd, rd, ja;
  wire         ws, rs, byp, host_interrupt, rdy, ee, emu, jv;
  wire  [4:0]  pm;
  wire  [1:0]  pd;
  logic [31:0] d;
  int          mismatches = 0;
  int          checks_done = 0;
  bphs_boot_seq i_dut (.CORE_CLK(clk), .RST_N(rst_n), .BOOT_MODE(md), .FAST_BOOT(fb),
    .PCI_ENABLE_STRAP(pe), .BUS_CONFIG_STRAP(bc), .PLL_MULT_STRAP(ms), .REG_ADDR(ra),
    .REG_WDATA(wd), .REG_WR(ws), .REG_RD(rs), .REG_RDATA(rd), .PLL_MULTIPLIER_VALUE(pm),
    .PLL_POSTDIV(pd), .PLL_BYPASS(byp), .HOST_INTERRUPT(host_interrupt), .PCI_CONFIG_READY(rdy),
    .EE_READ_REQ(ee), .EMU_IDLE(emu), .JUMP_VALID(jv), .JUMP_ADDR(ja));
  bphs_host_model u_host (.clk(clk), .addr(ra), .wdata(wd), .wstb(ws), .rstb(rs), .rdata(rd));
  always #50 clk = ~clk;
  function automatic logic [4:0] mult();
    logic [39:0] t = {5'h1D, 5'h1A, 5'h18, 5'h15, 5'h11, 5'h0F, 5'h0E, 5'h13};
    if (bc == 3'h1)
      return (!pe && md == 4'h1) ? 5'h1A : (!pe && md == 4'h3) ? 5'h0E : 5'h13;
    return t[ms*5 +: 5];
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask
  task automatic rst(input logic [3:0] m, input logic f, p, input logic [2:0] b, s);
    rst_n <= 1'b0;
    {md, fb, pe, bc, ms} <= {m, f, p, b, s};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic till(input int k);
    for (int n = 0; n < 200 && (k ? jv : rdy | host_interrupt) !== 1'b1; n++) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic t_pll();
    for (int k = 0; k < 11; k++) begin
      rst(k == 9 ? 4'h3 : k > 7 ? 4'h1 : 4'h4, 1'b1, k == 10, k > 7 ? 3'h1 : {3{k[2]}}, k[2:0]);
      repeat (10) @(posedge clk);
      chk("mult", pm, mult());
      chk("postdiv", pd, 2'h1);
    end
  endtask
  task automatic t_emu();
    rst(4'h0, 1'b1, 1'b0, 3'h1, 3'h7);
    repeat (40) @(posedge clk);
    chk("emu", {byp, emu, jv}, 3'h6);
  endtask
  task automatic t_host();
    rst(4'h1, 1'b1, 1'b0, 3'h0, 3'h5);
    till(0);
    chk("host_interrupt", host_interrupt, 1'b1);
    u_host.get(4'h2, d);
    chk("addr", d, 32'h0);
    u_host.get(4'h3, d);
    chk("done", d, 32'h0);
    u_host.get(4'hF, d);
    chk("unmapped", d, 32'h0);
    u_host.put(4'h2, 32'h8000_1234);
    u_host.rel();
    repeat (30) @(posedge clk);
    chk("early", jv, 1'b0);
    chk("host_interrupt end", host_interrupt, 1'b0);
    u_host.put(4'h3, 32'h1);
    u_host.rel();
    till(1);
    chk("jump", ja, 32'h8000_1234);
  endtask
  // Slow boot is still attempted when fast boot is off.
  task automatic t_pci1();
    rst(4'h1, 1'b0, 1'b1, 3'h0, 3'h0);
    till(0);
    chk("no host_interrupt", host_interrupt, 1'b0);
    u_host.get(4'h5, d);
    chk("target", {d[30:0], rdy}, 32'h3);
    u_host.load(32'h0010_0000);
    till(1);
    chk("jump", ja, 32'h0010_0000);
  endtask
  task automatic t_pci2(input logic g);
    logic [7:0] s = 8'hAA;
    rst(4'h2, 1'b1, 1'b1, 3'h0, 3'h4);
    chk("ready", rdy, 1'b0);
    for (int i = 0; i < 26; i++) begin
      u_host.put(4'h7, {19'h0, i[4:0], 8'h3C ^ i[7:0]});
      s = s ^ 8'h3C ^ i[7:0];
    end
    u_host.put(4'h7, {19'h0, 5'h1A, s ^ {7'h0, !g}});
    chk("ee busy", ee, 1'b1);
    u_host.rel();
    repeat (60) @(posedge clk);
    u_host.get(4'h3, d);
    chk("ee idle", ee, 1'b0);
    chk("fault", {d[15:8], rdy}, g ? 9'h001 : 9'h002);
    if (g) begin
      u_host.load(32'h0020_0040);
      till(1);
      chk("jump", ja, 32'h0020_0040);
    end
  endtask
  initial begin
    t_pll();
    t_emu();
    t_host();
    t_pci1();
    t_pci2(1'b1);
    t_pci2(1'b0);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule // bphs_boot_seq_tb

//--- tb/bphs_host_model.sv
// Host processor model driving the register port.
`timescale 1ns/1ps
module bphs_host_model (
  // Register port
  input  wire         clk,
  output logic [3:0]  addr,
  output logic [31:0] wdata,
  output logic        wstb,
  output logic        rstb,
  input  wire  [31:0] rdata
);
  initial begin
    addr = 4'h0;
    wdata = 32'h0;
    wstb = 1'b0;
    rstb = 1'b0;
  end
  // The strobe stays high so writes run back to back; rel ends a burst.
  task automatic put(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wstb <= 1'b1;
    rstb <= 1'b0;
    @(posedge clk);
  endtask
  // Released lines show the inverse so a stale value cannot pass.
  task automatic rel();
    wstb <= 1'b0;
    addr <= ~addr;
    wdata <= ~wdata;
  endtask
  task automatic get(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rstb <= 1'b1;
    wstb <= 1'b0;
    @(posedge clk);
    rstb <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic load(input logic [31:0] a);
    put(4'h2, a);
    put(4'h3, 32'h1);
    rel();
  endtask
endmodule // bphs_host_model

//--- verilog/bphs_boot_seq.v
// Boot sequencer: strap capture, multiplier choice and host boot handshake.
`timescale 1ns/1ps
`include "bphs_regs.vh"
module bphs_boot_seq (
  // Clock and reset
  input  wire        CORE_CLK,
  input  wire        RST_N,
  // Strap pins
  input  wire [3:0]  BOOT_MODE,
  input  wire        FAST_BOOT,
  input  wire        PCI_ENABLE_STRAP,
  input  wire [2:0]  BUS_CONFIG_STRAP,
  input  wire [2:0]  PLL_MULT_STRAP,
  // Register port
  input  wire [3:0]  REG_ADDR,
  input  wire [31:0] REG_WDATA,
  input  wire        REG_WR,
  input  wire        REG_RD,
  output reg  [31:0] REG_RDATA,
  // Sequencer outputs
  output reg  [4:0]  PLL_MULTIPLIER_VALUE,
  output reg  [1:0]  PLL_POSTDIV,
  output reg         PLL_BYPASS,
  output reg         HOST_INTERRUPT,
  output reg         PCI_CONFIG_READY,
  output reg         EE_READ_REQ,
  output reg         EMU_IDLE,
  output reg         JUMP_VALID,
  output reg  [31:0] JUMP_ADDR
);

  localparam HOST_INTERRUPT_CYC = (`BPHS_HOST_INTERRUPT_NS + `BPHS_CLK_NS - 1) / `BPHS_CLK_NS;

  // Sequencer states, one-hot:
  //   LATCH  waits for agreeing straps and captures them.
  //   DECIDE picks the path from the latched mode and fast boot choice.
  //   PLL    programs multiplier and divider and leaves bypass.
  //   CLEAR  clears the handshake registers and starts the host signal (PCI strap off), PCI ready (mode 1) or the image walk (auto-init set).
  //   SIGNAL holds the host interrupt for its fixed length.
  //   EEREAD walks the auto-init image and checks its checksum.
  //   POLL   waits for the host to set the done bit.
  //   JUMP   hands over to the host address; terminal.
  //   EMU    idles for the debugger; terminal.
  //   FAIL   stands in for the serial fallback after a bad image; terminal.
  localparam S_LATCH  = 10'h001;
  localparam S_DECIDE = 10'h002;
  localparam S_PLL    = 10'h004;
  localparam S_CLEAR  = 10'h008;
  localparam S_SIGNAL = 10'h010;
  localparam S_EEREAD = 10'h020;
  localparam S_POLL   = 10'h040;
  localparam S_JUMP   = 10'h080;
  localparam S_EMU    = 10'h100;
  localparam S_FAIL   = 10'h200;

  reg        rst_m_r;
  reg        rst_s_r;
  wire       rst_n = rst_s_r;

  reg  [9:0]  state_r;
  reg  [3:0]  mode_r;
  reg         fast_r;
  reg         pci_enable_strap_r;
  reg  [2:0]  buscfg_r;
  reg  [2:0]  pll_mult_strap_r;
  reg  [31:0] boot_addr_r;
  reg         done_r;
  reg  [7:0]  err_r;
  reg         pci_target_r;
  reg  [7:0]  chk_r;
  reg  [4:0]  ee_idx_r;
  reg  [3:0]  host_interrupt_cnt_r;
  reg  [7:0]  ee_mem_r [0:26];
  reg         auto_init_r;
  reg  [9:0]  state_nxt;
  reg  [31:0] rdata_nxt;
  reg  [11:0] strap_s1_r;
  reg  [11:0] strap_s2_r;
  reg  [11:0] strap_s3_r;

  // Multiplier choice from the latched straps only.
  function [4:0] pick_mult;
    input [2:0] bc;
    input [2:0] ms;
    input [3:0] md;
    input       pe;
    begin
      if (bc == `BPHS_BUSCFG_FIXED) begin
        if (md == `BPHS_MODE_1 && !pe)
          pick_mult = 5'h1A;
        else if (md == `BPHS_MODE_3 && !pe)
          pick_mult = 5'h0E;
        else
          pick_mult = 5'h13;
      end else begin
        case (ms)
          3'h0:    pick_mult = 5'h13;
          3'h1:    pick_mult = 5'h0E;
          3'h2:    pick_mult = 5'h0F;
          3'h3:    pick_mult = 5'h11;
          3'h4:    pick_mult = 5'h15;
          3'h5:    pick_mult = 5'h18;
          3'h6:    pick_mult = 5'h1A;
          default: pick_mult = 5'h1D;
        endcase
      end
    end
  endfunction

  wire host_mode = (mode_r == `BPHS_MODE_1) || (mode_r == `BPHS_MODE_2) ||
                   (mode_r == `BPHS_MODE_3);
  wire done_wr   = REG_WR && (REG_ADDR == `BPHS_OFF_DONE);
  wire [7:0] ee_byte = ee_mem_r[ee_idx_r];
  wire       chk_ok  = (chk_r == ee_mem_r[`BPHS_EE_CHK_IDX]);
  wire       straps_agree = (strap_s2_r == strap_s3_r);

  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end

  // Strap pins are asynchronous to the core clock. Each bit passes three
  // flops, and the sampled word counts only once the second and third
  // stages agree, so a strap still settling when reset lifts keeps the
  // sequencer in its latch state rather than being caught half way.
  // The stages carry no reset on purpose: they fill with the pin levels
  // while the device is held in reset, so nothing is lost at release.
  always @(posedge CORE_CLK) begin
    strap_s1_r <= {BOOT_MODE, FAST_BOOT, PCI_ENABLE_STRAP, BUS_CONFIG_STRAP,
                   PLL_MULT_STRAP};
    strap_s2_r <= strap_s1_r;
    strap_s3_r <= strap_s2_r;
  end

  // Straps are caught once after reset release and then held until the
  // next reset; later pin activity has no effect on the boot decision.
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_r   <= 4'h0;
      fast_r   <= 1'b0;
      pci_enable_strap_r  <= 1'b0;
      buscfg_r <= 3'h0;
      pll_mult_strap_r  <= 3'h0;
    end else if (state_r == S_LATCH && straps_agree) begin
      mode_r   <= strap_s3_r[11:8];
      fast_r   <= strap_s3_r[7];
      pci_enable_strap_r  <= strap_s3_r[6];
      buscfg_r <= strap_s3_r[5:3];
      pll_mult_strap_r  <= strap_s3_r[2:0];
    end
  end

  // Auto-init image store, loaded by software standing in for the EEPROM
  // read engine at its fixed target address.
  always @(posedge CORE_CLK) begin
    if (REG_WR && REG_ADDR == `BPHS_OFF_EE_DATA && REG_WDATA[12:8] <= `BPHS_EE_BYTES - 5'h1)
      ee_mem_r[REG_WDATA[12:8]] <= REG_WDATA[7:0];
  end

  // Next state. The sequencer only moves forward; JUMP, EMU and FAIL hold
  // until the next reset, as the boot code does once it has handed over
  // or given up.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_LATCH: begin
        if (straps_agree)
          state_nxt = S_DECIDE;
      end
      S_DECIDE: begin
        if (mode_r == `BPHS_MODE_EMU)
          state_nxt = S_EMU;
        else if (fast_r)
          state_nxt = S_PLL;
        else if (host_mode)
          state_nxt = S_CLEAR;
        else
          state_nxt = S_JUMP;
      end
      S_PLL: begin
        state_nxt = host_mode ? S_CLEAR : S_JUMP;
      end
      S_CLEAR: begin
        if (!pci_enable_strap_r)
          state_nxt = S_SIGNAL;
        else if (mode_r == `BPHS_MODE_1 || !auto_init_r)
          state_nxt = S_POLL;
        else
          state_nxt = S_EEREAD;
      end
      S_SIGNAL: begin
        if (host_interrupt_cnt_r == 4'h1)
          state_nxt = S_POLL;
      end
      S_EEREAD: begin
        if (ee_idx_r > `BPHS_EE_LAST_CFG)
          state_nxt = chk_ok ? S_POLL : S_FAIL;
      end
      S_POLL: begin
        if (done_r)
          state_nxt = S_JUMP;
      end
      S_JUMP:  state_nxt = S_JUMP;
      S_EMU:   state_nxt = S_EMU;
      S_FAIL:  state_nxt = S_FAIL;
      default: state_nxt = S_LATCH;
    endcase
  end

  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r              <= S_LATCH;
      boot_addr_r          <= 32'h0;
      done_r               <= 1'b0;
      err_r                <= 8'h0;
      pci_target_r         <= 1'b0;
      PCI_CONFIG_READY     <= 1'b0;
      PLL_MULTIPLIER_VALUE <= 5'h0;
      PLL_POSTDIV          <= 2'h0;
      PLL_BYPASS           <= 1'b1;
      HOST_INTERRUPT       <= 1'b0;
      EE_READ_REQ          <= 1'b0;
      EMU_IDLE             <= 1'b0;
      JUMP_VALID           <= 1'b0;
      JUMP_ADDR            <= 32'h0;
      chk_r                <= 8'h0;
      ee_idx_r             <= 5'h0;
      host_interrupt_cnt_r           <= 4'h0;
      auto_init_r          <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // Host writes are honoured in every state but CLEAR, polling included.
      if (REG_WR && REG_ADDR == `BPHS_OFF_BOOT_ADDR)
        boot_addr_r <= REG_WDATA;
      if (done_wr)
        done_r <= REG_WDATA[`BPHS_DONE_BIT];
      // The clear below comes after the host writes, so in the one cycle
      // of CLEAR the clear wins; a host must not write before the signal.
      case (state_r)
        S_DECIDE: begin
          auto_init_r <= (mode_r == `BPHS_MODE_2) && pci_enable_strap_r && fast_r;
        end
        S_PLL: begin
          // No range check on the result: straps are trusted.
          PLL_MULTIPLIER_VALUE <= pick_mult(buscfg_r, pll_mult_strap_r, mode_r, pci_enable_strap_r);
          PLL_POSTDIV          <= `BPHS_POSTDIV_FIXED;
          PLL_BYPASS           <= 1'b0;
        end
        S_CLEAR: begin
          boot_addr_r <= 32'h0;
          done_r      <= 1'b0;
          err_r       <= 8'h0;
          if (!pci_enable_strap_r) begin
            HOST_INTERRUPT <= 1'b1;
            host_interrupt_cnt_r     <= HOST_INTERRUPT_CYC[3:0];
          end else if (mode_r == `BPHS_MODE_1) begin
            PCI_CONFIG_READY <= 1'b1;
            pci_target_r     <= 1'b1;
          end else if (auto_init_r) begin
            chk_r       <= `BPHS_CHK_SEED;
            ee_idx_r    <= 5'h0;
            EE_READ_REQ <= 1'b1;
          end
        end
        S_SIGNAL: begin
          if (host_interrupt_cnt_r == 4'h1)
            HOST_INTERRUPT <= 1'b0;
          host_interrupt_cnt_r <= host_interrupt_cnt_r - 4'h1;
        end
        S_EEREAD: begin
          if (ee_idx_r <= `BPHS_EE_LAST_CFG) begin
            chk_r    <= chk_r ^ ee_byte;
            ee_idx_r <= ee_idx_r + 5'h1;
          end else begin
            EE_READ_REQ <= 1'b0;
            if (chk_ok)
              PCI_CONFIG_READY <= 1'b1;
            else
              err_r <= `BPHS_ERR_CHECKSUM;
          end
        end
        S_JUMP: begin
          // The target is taken once; a later host write must not move it.
          if (!JUMP_VALID) begin
            JUMP_VALID <= 1'b1;
            JUMP_ADDR  <= boot_addr_r;
          end
        end
        S_EMU: EMU_IDLE <= 1'b1;
        default: ;
      endcase
    end
  end

  // Read port: data stand in the cycle after the strobe and only there,
  // and read as zero otherwise, so a stale word is never taken twice.
  // The control word and the image port read as zero; the image port is
  // write only, since the sequencer alone consumes what is stored there.
  always @* begin
    rdata_nxt = 32'h0;
    if (REG_RD) begin
      case (REG_ADDR)
        `BPHS_OFF_STATUS:     rdata_nxt = {22'h0, state_r};
        `BPHS_OFF_BOOT_ADDR:  rdata_nxt = boot_addr_r;
        `BPHS_OFF_DONE:       rdata_nxt = {16'h0, err_r, 7'h0, done_r};
        `BPHS_OFF_PCI_READY:  rdata_nxt = {31'h0, PCI_CONFIG_READY};
        `BPHS_OFF_PCI_TARGET: rdata_nxt = {31'h0, pci_target_r};
        `BPHS_OFF_PLL:        rdata_nxt = {24'h0, PLL_BYPASS, PLL_POSTDIV,
                                           PLL_MULTIPLIER_VALUE};
        `BPHS_OFF_STRAPS:     rdata_nxt = {20'h0, buscfg_r, pll_mult_strap_r, pci_enable_strap_r,
                                           fast_r, mode_r};
        default:              rdata_nxt = 32'h0;
      endcase
    end
  end

  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n)
      REG_RDATA <= 32'h0;
    else
      REG_RDATA <= rdata_nxt;
  end

endmodule // bphs_boot_seq

//--- verilog/bphs_regs.vh
// Register offsets, field positions and timing counts for the boot sequencer.
`ifndef BPHS_REGS_VH
`define BPHS_REGS_VH
`define BPHS_ADDR_W          4
`define BPHS_OFF_CTRL        4'h0
`define BPHS_OFF_STATUS      4'h1
`define BPHS_OFF_BOOT_ADDR   4'h2
`define BPHS_OFF_DONE        4'h3
`define BPHS_OFF_PCI_READY   4'h4
`define BPHS_OFF_PCI_TARGET  4'h5
`define BPHS_OFF_PLL         4'h6
`define BPHS_OFF_EE_DATA     4'h7
`define BPHS_OFF_STRAPS      4'h8
`define BPHS_DONE_BIT        0
`define BPHS_ERR_LSB         8
`define BPHS_ERR_MSB         15
`define BPHS_ERR_CHECKSUM    8'h01
`define BPHS_MODE_EMU        4'h0
`define BPHS_MODE_1          4'h1
`define BPHS_MODE_2          4'h2
`define BPHS_MODE_3          4'h3
`define BPHS_MODE_UART       4'h8
`define BPHS_BUSCFG_FIXED    3'h1
`define BPHS_PLL_MULTIPLIER_VALUE_W          5
`define BPHS_POSTDIV_FIXED   2'h1
`define BPHS_CHK_SEED        8'hAA
`define BPHS_EE_BYTES        5'h1B
`define BPHS_EE_LAST_CFG     5'h19
`define BPHS_EE_CHK_IDX      5'h1A
`define BPHS_HOST_INTERRUPT_NS         1000
`define BPHS_CLK_NS          100
`endif
